/* rtl/point_cloud_body_safety_framer.sv */
// Point-cloud body and functional-safety section framer with APB registers
`timescale 1ns/1ps
`default_nettype none
module point_cloud_body_safety_framer
  import framer_pkg::*;
#(
  parameter int ROLL_CYCLES = ROLL_CYCLES_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_start,
  input wire logic [15:0] azimuth_first,
  input wire logic [15:0] azimuth_second,
  output logic frame_ready,
  output logic [6:0] meas_channel,
  output logic meas_block,
  input wire logic meas_valid,
  output logic meas_ready,
  input wire logic meas_fired,
  input wire logic [1:0] meas_hits,
  input wire logic [15:0] first_dist,
  input wire logic [7:0] first_refl,
  input wire logic [15:0] second_dist,
  input wire logic [7:0] second_refl,
  input wire logic [15:0] last_dist,
  input wire logic [7:0] last_refl,
  input wire logic [15:0] strong_dist,
  input wire logic [7:0] strong_refl,
  input wire logic [15:0] strong2_dist,
  input wire logic [7:0] strong2_refl,
  input wire logic first_is_strongest,
  input wire logic last_is_strongest,
  output logic [7:0] out_byte,
  output logic out_valid,
  output logic out_last,
  input wire logic out_ready,
  output logic firing_order
);

  if (ROLL_CYCLES < 1) begin : g_bad_roll
    $error("ROLL_CYCLES must be at least one");
  end

  typedef struct packed {
    state_type state;
    logic [4:0] sub;
    logic [6:0] chan;
    logic blk;
    logic [15:0] az1;
    logic [15:0] az2;
    logic [31:0] rec;
    logic [31:0] crc;
    logic [7:0] obyte;
    logic ovalid;
    logic olast;
    logic [7:0] mode;
    logic blk_en;
    logic [7:0] ctrl_mode;
    logic ctrl_blk_en;
    logic [2:0] lstate;
    logic [1:0] ftype;
    logic [3:0] ftotal;
    logic [3:0] fpos;
    logic [15:0] fcode;
    logic [31:0] prdata;
    logic pslverr;
    logic [2:0] roll;
    logic [31:0] tick;
    logic fire_order;
    logic [15:0] pkt_cnt;
    logic [10:0] sent;
  } regs_type;

  localparam regs_type REGS_RESET = '{
    state: S_IDLE,
    ctrl_mode: CTRL_MODE_RESET,
    mode: CTRL_MODE_RESET,
    lstate: LIDAR_STATE_RESET,
    fire_order: 1'b1,
    default: '0
  };

  regs_type st;
  regs_type next_st;

  logic [15:0] sel_dist;
  logic [7:0] sel_refl;
  logic [31:0] rec_word;
  logic is_dual;
  logic slot_free;
  logic [7:0] safe_byte;
  logic [31:0] reg_rdata;
  logic reg_hit;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[31] ^ d[i];
      r = {r[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h00000000);
    end
    return r;
  endfunction : crc_byte

  function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [1:0] idx);
    return 8'(w >> {idx, 3'b000});
  endfunction : pick_byte

  assign is_dual = (st.mode == DUAL_LAST_STRONG) || (st.mode == DUAL_FIRST_SECOND) ||
                   (st.mode == DUAL_FIRST_LAST) || (st.mode == DUAL_FIRST_STRONG) ||
                   (st.mode == DUAL_STRONG_SECOND);

  // Return selection per block; in dual modes both blocks read the same round
  always_comb begin
    sel_dist = first_dist;
    sel_refl = first_refl;
    case (st.mode)
      RET_SECOND: begin
        sel_dist = second_dist;
        sel_refl = second_refl;
      end
      RET_STRONG: begin
        sel_dist = strong_dist;
        sel_refl = strong_refl;
      end
      RET_LAST: begin
        sel_dist = last_dist;
        sel_refl = last_refl;
      end
      DUAL_LAST_STRONG: begin
        if (!st.blk) begin
          sel_dist = last_dist;
          sel_refl = last_refl;
        end else if (last_is_strongest) begin
          sel_dist = strong2_dist;
          sel_refl = strong2_refl;
        end else begin
          sel_dist = strong_dist;
          sel_refl = strong_refl;
        end
      end
      DUAL_FIRST_STRONG: begin
        if (st.blk && first_is_strongest) begin
          sel_dist = strong2_dist;
          sel_refl = strong2_refl;
        end else if (st.blk) begin
          sel_dist = strong_dist;
          sel_refl = strong_refl;
        end
      end
      DUAL_FIRST_LAST: begin
        if (st.blk && meas_hits != 2'h1) begin
          sel_dist = last_dist;
          sel_refl = last_refl;
        end
      end
      DUAL_STRONG_SECOND: begin
        if (st.blk && meas_hits != 2'h1) begin
          sel_dist = strong2_dist;
          sel_refl = strong2_refl;
        end else begin
          sel_dist = strong_dist;
          sel_refl = strong_refl;
        end
      end
      DUAL_FIRST_SECOND: begin
        if (st.blk && meas_hits != 2'h1) begin
          sel_dist = second_dist;
          sel_refl = second_refl;
        end
      end
      default: begin
        sel_dist = first_dist;
        sel_refl = first_refl;
      end
    endcase
  end

  // Record word, byte 0 first on the wire
  always_comb begin
    if (!meas_fired) begin
      rec_word = 32'h00000000;
    end else if (meas_hits != 2'h0 && sel_dist >= MIN_DIST) begin
      rec_word = {8'h00, sel_refl, sel_dist};
    end else begin
      // Blockage setting picks the no-point flag
      rec_word = {8'h00, sel_refl, st.blk_en ? NO_POINT_FLAG : NO_EMIT_FLAG};
    end
  end

  always_comb begin
    case (st.sub)
      5'h00: safe_byte = SAFETY_VERSION;
      5'h01: safe_byte = {st.lstate, st.ftype, st.roll};
      5'h02: safe_byte = {st.ftotal, st.fpos};
      5'h03: safe_byte = st.fcode[7:0];
      5'h04: safe_byte = st.fcode[15:8];
      5'h0D, 5'h0E, 5'h0F, 5'h10: safe_byte = pick_byte(st.crc, 2'(st.sub - SAFE_CRC_FIRST));
      default: safe_byte = 8'h00;
    endcase
  end

  always_comb begin
    reg_hit = 1'b1;
    case (paddr)
      ADDR_CTRL: reg_rdata = 32'(st.ctrl_blk_en) | (32'(st.ctrl_mode) << CTRL_MODE_LSB);
      ADDR_SAFETY: reg_rdata = (32'(st.lstate) << SAFETY_STATE_LSB) |
                               (32'(st.ftype) << SAFETY_FTYPE_LSB) |
                               (32'(st.ftotal) << SAFETY_TOTAL_LSB) |
                               (32'(st.fpos) << SAFETY_POS_LSB);
      ADDR_FAULT: reg_rdata = 32'(st.fcode);
      ADDR_STATUS: reg_rdata = (32'(st.state != S_IDLE) << STATUS_BUSY_BIT) |
                               (32'(st.fire_order) << STATUS_ORDER_BIT) |
                               (32'(st.roll) << STATUS_ROLL_LSB) |
                               (32'(st.pkt_cnt) << STATUS_PKT_LSB);
      default: begin
        reg_rdata = 32'h00000000;
        reg_hit = 1'b0;
      end
    endcase
  end

  assign slot_free = !st.ovalid || out_ready;

  always_comb begin
    next_st = st;
    if (st.ovalid && out_ready) begin
      next_st.ovalid = 1'b0;
      next_st.olast = 1'b0;
      next_st.sent = st.sent + 11'h001;
    end
    // Rolling counter keeps running while frames stall, so a stuck reporter shows
    if (st.tick >= 32'(ROLL_CYCLES - 1)) begin
      next_st.tick = 32'h00000000;
      next_st.roll = st.roll + 3'h1;
    end else begin
      next_st.tick = st.tick + 32'h00000001;
    end
    // APB: answer prepared in setup, presented in the access phase
    if (psel && !penable) begin
      next_st.prdata = pwrite ? 32'h00000000 : reg_rdata;
      next_st.pslverr = !reg_hit;
    end
    if (psel && penable && pwrite) begin
      case (paddr)
        ADDR_CTRL: begin
          next_st.ctrl_blk_en = pwdata[CTRL_BLOCKAGE_BIT];
          next_st.ctrl_mode = pwdata[CTRL_MODE_LSB +: 8];
        end
        ADDR_SAFETY: begin
          next_st.lstate = pwdata[SAFETY_STATE_LSB +: 3];
          next_st.ftype = pwdata[SAFETY_FTYPE_LSB +: 2];
          next_st.ftotal = pwdata[SAFETY_TOTAL_LSB +: 4];
          next_st.fpos = pwdata[SAFETY_POS_LSB +: 4];
        end
        ADDR_FAULT: next_st.fcode = pwdata[15:0];
        default: next_st.fcode = st.fcode;
      endcase
    end
    case (st.state)
      S_IDLE: begin
        if (frame_start) begin
          // Return mode and blockage settings are frozen per packet so a frame never mixes encodings
          next_st.mode = st.ctrl_mode;
          next_st.blk_en = st.ctrl_blk_en;
          next_st.az1 = azimuth_first;
          next_st.az2 = azimuth_second;
          next_st.crc = CRC_INIT;
          next_st.sub = 5'h00;
          next_st.chan = 7'h00;
          next_st.blk = 1'b0;
          next_st.sent = 11'h000;
          next_st.state = S_AZ;
          case (st.ctrl_mode)
            DUAL_LAST_STRONG, DUAL_FIRST_SECOND, DUAL_FIRST_LAST, DUAL_FIRST_STRONG,
            DUAL_STRONG_SECOND: next_st.fire_order = !st.fire_order;
            default: next_st.fire_order = 1'b1;
          endcase
        end
      end
      S_AZ: begin
        if (slot_free) begin
          next_st.obyte = pick_byte({16'h0000, st.blk ? st.az2 : st.az1}, st.sub[1:0]);
          next_st.ovalid = 1'b1;
          next_st.crc = crc_byte(st.crc, next_st.obyte);
          next_st.sub = st.sub + 5'h01;
          if (st.sub[0]) begin
            next_st.sub = 5'h00;
            next_st.state = S_FETCH;
          end
        end
      end
      S_FETCH: begin
        if (meas_valid) begin
          next_st.rec = rec_word;
          next_st.sub = 5'h00;
          next_st.state = S_REC;
        end
      end
      S_REC: begin
        if (slot_free) begin
          next_st.obyte = pick_byte(st.rec, st.sub[1:0]);
          next_st.ovalid = 1'b1;
          next_st.crc = crc_byte(st.crc, next_st.obyte);
          next_st.sub = st.sub + 5'h01;
          if (st.sub == 5'h03) begin
            next_st.sub = 5'h00;
            next_st.chan = st.chan + 7'h01;
            next_st.state = S_FETCH;
            if (st.chan == 7'(CHANNELS - 1)) begin
              next_st.blk = 1'b1;
              next_st.state = st.blk ? S_CRC : S_AZ;
            end
          end
        end
      end
      S_CRC: begin
        if (slot_free) begin
          next_st.obyte = pick_byte(st.crc, st.sub[1:0]);
          next_st.ovalid = 1'b1;
          next_st.sub = st.sub + 5'h01;
          if (st.sub == 5'h03) begin
            next_st.sub = 5'h00;
            next_st.crc = CRC_INIT;
            next_st.state = S_SAFE;
          end
        end
      end
      S_SAFE: begin
        if (slot_free) begin
          next_st.obyte = safe_byte;
          next_st.ovalid = 1'b1;
          next_st.sub = st.sub + 5'h01;
          if (st.sub != 5'h00 && st.sub < SAFE_CRC_FIRST) begin
            next_st.crc = crc_byte(st.crc, safe_byte);
          end
          if (st.sub == SAFE_LAST) begin
            next_st.olast = 1'b1;
            next_st.pkt_cnt = st.pkt_cnt + 16'h0001;
            next_st.state = S_IDLE;
          end
        end
      end
      default: next_st.state = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= REGS_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = psel && penable;
  assign pslverr = st.pslverr;
  assign frame_ready = (st.state == S_IDLE);
  assign meas_ready = (st.state == S_FETCH);
  assign meas_channel = st.chan;
  assign meas_block = st.blk;
  assign out_byte = st.obyte;
  assign out_valid = st.ovalid;
  assign out_last = st.olast;
  assign firing_order = st.fire_order;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  frame_length_a: assert property (
    out_valid && out_ready && out_last |-> st.sent == FRAME_BYTES - 11'h001)
    else $error("frame length wrong");

  unfired_zero_a: assert property (
    st.state == S_FETCH && meas_valid && !meas_fired |=> st.rec == 32'h00000000)
    else $error("unfired record not zero");

  blockage_flag_a: assert property (
    st.state == S_FETCH && meas_valid && meas_fired && meas_hits == 2'h0 && st.blk_en
    |=> st.rec[15:0] == NO_POINT_FLAG)
    else $error("no-return flag wrong");

  dist_legal_a: assert property (
    st.state == S_REC |-> st.rec[15:0] <= NO_POINT_FLAG || st.rec[15:0] >= MIN_DIST)
    else $error("distance below minimum");

  safe_version_a: assert property (
    st.state == S_SAFE && st.sub == 5'h00 && slot_free |=> out_byte == SAFETY_VERSION)
    else $error("safety version wrong");

  roll_step_a: assert property (
    st.roll != $past(st.roll) |-> st.roll == $past(st.roll) + 3'h1 && st.tick == 32'h0)
    else $error("rolling counter step wrong");

  order_toggle_a: assert property (
    st.state == S_IDLE && frame_start && is_dual_next(st.ctrl_mode)
    |=> firing_order != $past(firing_order))
    else $error("firing order did not alternate");

  crc_hold_a: assert property (
    st.state == S_CRC && !slot_free |=> $stable(st.crc) && st.state == S_CRC)
    else $error("checksum moved while stalled");

  dual_same_a: assert property (
    st.state == S_FETCH && meas_valid && meas_fired && st.blk && meas_hits == 2'h1 &&
    st.mode == DUAL_FIRST_SECOND && first_dist >= MIN_DIST |=> st.rec[15:0] == $past(first_dist))
    else $error("single return not copied");

  single_order_a: assert property (
    !is_dual |-> firing_order)
    else $error("single-return order bit not fixed");

  function automatic logic is_dual_next(input logic [7:0] m);
    return m == DUAL_LAST_STRONG || m == DUAL_FIRST_SECOND || m == DUAL_FIRST_LAST ||
           m == DUAL_FIRST_STRONG || m == DUAL_STRONG_SECOND;
  endfunction : is_dual_next

endmodule : point_cloud_body_safety_framer
`default_nettype wire

/* rtl/framer_pkg.sv */
// Constants and types shared by the point-cloud body and safety framer
package framer_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int ROLL_PERIOD_NS = 5000000;
  localparam int ROLL_CYCLES_DEFAULT = ROLL_PERIOD_NS / CLK_PERIOD_NS;

  // Frame layout
  localparam int CHANNELS = 128;
  localparam int BODY_BYTES = 1032;
  localparam int SAFE_BYTES = 17;
  localparam logic [4:0] SAFE_CRC_FIRST = 5'h0D;
  localparam logic [4:0] SAFE_LAST = 5'h10;
  localparam logic [4:0] SAFE_RSV_FIRST = 5'h05;
  localparam logic [10:0] FRAME_BYTES = 11'h419;

  // Checksum
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;

  // Field values
  localparam logic [7:0] SAFETY_VERSION = 8'h01;
  localparam logic [15:0] MIN_DIST = 16'h000C;
  localparam logic [15:0] NO_POINT_FLAG = 16'h0001;
  localparam logic [15:0] NO_EMIT_FLAG = 16'h0000;
  localparam int STATE_LSB = 5;
  localparam int FTYPE_LSB = 3;

  // Return modes
  localparam logic [7:0] RET_FIRST = 8'h33;
  localparam logic [7:0] RET_SECOND = 8'h34;
  localparam logic [7:0] RET_STRONG = 8'h37;
  localparam logic [7:0] RET_LAST = 8'h38;
  localparam logic [7:0] DUAL_LAST_STRONG = 8'h39;
  localparam logic [7:0] DUAL_FIRST_SECOND = 8'h3A;
  localparam logic [7:0] DUAL_FIRST_LAST = 8'h3B;
  localparam logic [7:0] DUAL_FIRST_STRONG = 8'h3C;
  localparam logic [7:0] DUAL_STRONG_SECOND = 8'h3E;

  // Register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SAFETY = 8'h04;
  localparam logic [7:0] ADDR_FAULT = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam int CTRL_BLOCKAGE_BIT = 0;
  localparam int CTRL_MODE_LSB = 8;
  localparam int SAFETY_STATE_LSB = 0;
  localparam int SAFETY_FTYPE_LSB = 3;
  localparam int SAFETY_TOTAL_LSB = 8;
  localparam int SAFETY_POS_LSB = 12;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_ORDER_BIT = 1;
  localparam int STATUS_ROLL_LSB = 2;
  localparam int STATUS_PKT_LSB = 16;

  // Reset values
  localparam logic [7:0] CTRL_MODE_RESET = RET_FIRST;
  localparam logic [2:0] LIDAR_STATE_RESET = 3'h0;

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_AZ = 6'b000010,
    S_FETCH = 6'b000100,
    S_REC = 6'b001000,
    S_CRC = 6'b010000,
    S_SAFE = 6'b100000
  } state_type;
endpackage : framer_pkg

/* verification/host_receiver.sv */
// Host-side byte sink with random back-pressure on the framer output
`timescale 1ns/1ps
`default_nettype none
module host_receiver (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] out_byte,
  input wire logic out_valid,
  input wire logic out_last,
  output var logic out_ready
);
  logic [31:0] seed = 32'h00001D2F;
  logic [7:0] rx_q[$];
  logic rx_l[$];
  time rx_t[$];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ready <= 1'b0;
    end else begin
      if (out_valid && out_ready) begin
        rx_q.push_back(out_byte);
        rx_l.push_back(out_last);
        rx_t.push_back($time);
      end
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      // Stall about a quarter of cycles so held bytes get exercised
      out_ready <= seed[1:0] != 2'h0;
    end
  end
endmodule : host_receiver
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the point-cloud body and safety framer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import framer_pkg::*;
  localparam int ROLL = 4000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, frame_ready, meas_ready, meas_block, out_valid, out_last, out_ready;
  logic frame_start = 1'b0;
  logic [15:0] azimuth_first = 16'h0000;
  logic [15:0] azimuth_second = 16'h0000;
  logic [6:0] meas_channel;
  logic meas_valid = 1'b0;
  logic meas_fired = 1'b0;
  logic [1:0] meas_hits = 2'h0;
  logic [15:0] md [5] = '{default: 16'h0000};
  logic [7:0] mr [5] = '{default: 8'h00};
  logic first_is_strongest = 1'b0;
  logic last_is_strongest = 1'b0;
  logic [7:0] out_byte;
  logic firing_order;
  logic [31:0] seed = 32'h00002B37;
  int n_mismatch = 0;
  int tests_run = 0;
  int rs;
  time t_rel;
  logic [7:0] mode;
  logic dual = 1'b0;
  logic [7:0] exp_idx;
  logic [15:0] d [2][128][5];
  logic [7:0] r [2][128][5];
  logic [4:0] fl [2][128];
  logic [7:0] e[$];
  logic [7:0] modes [10] = '{RET_FIRST, RET_SECOND, RET_STRONG, RET_LAST, 8'h55,
    DUAL_LAST_STRONG, DUAL_FIRST_SECOND, DUAL_FIRST_LAST, DUAL_FIRST_STRONG, DUAL_STRONG_SECOND};

  always #5 pclk = ~pclk;

  point_cloud_body_safety_framer #(.ROLL_CYCLES(ROLL)) i_point_cloud_body_safety_framer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_start(frame_start), .azimuth_first(azimuth_first),
    .azimuth_second(azimuth_second), .frame_ready(frame_ready),
    .meas_channel(meas_channel), .meas_block(meas_block), .meas_valid(meas_valid),
    .meas_ready(meas_ready), .meas_fired(meas_fired), .meas_hits(meas_hits),
    .first_dist(md[0]), .first_refl(mr[0]), .second_dist(md[1]), .second_refl(mr[1]),
    .last_dist(md[2]), .last_refl(mr[2]), .strong_dist(md[3]), .strong_refl(mr[3]),
    .strong2_dist(md[4]), .strong2_refl(mr[4]), .first_is_strongest(first_is_strongest),
    .last_is_strongest(last_is_strongest), .out_byte(out_byte), .out_valid(out_valid),
    .out_last(out_last), .out_ready(out_ready), .firing_order(firing_order));

  host_receiver i_host_receiver (.pclk(pclk), .presetn(presetn), .out_byte(out_byte),
    .out_valid(out_valid), .out_last(out_last), .out_ready(out_ready));

  function automatic logic [31:0] rnd();
    for (int j = 0; j < 32; j++) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] b);
    for (int j = 7; j >= 0; j--) c = (c[31] ^ b[j]) ? {c[30:0], 1'b0} ^ CRC_POLY : {c[30:0], 1'b0};
    return c;
  endfunction : crc8

  // Return slot per block: 0 first, 1 second, 2 last, 3 strongest, 4 second strongest
  function automatic int pick(input logic [7:0] m, input logic b, input logic [4:0] f);
    case (m)
      RET_SECOND: return 1;
      RET_STRONG: return 3;
      RET_LAST: return 2;
      DUAL_LAST_STRONG: return b ? (f[4] ? 4 : 3) : 2;
      DUAL_FIRST_STRONG: return b ? (f[3] ? 4 : 3) : 0;
      DUAL_FIRST_LAST: return (b && f[2:1] != 2'h1) ? 2 : 0;
      DUAL_FIRST_SECOND: return (b && f[2:1] != 2'h1) ? 1 : 0;
      DUAL_STRONG_SECOND: return (b && f[2:1] != 2'h1) ? 4 : 3;
      default: return 0;
    endcase
  endfunction : pick

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic timed_out();
    n_mismatch++;
    $display("[ERR] %0t wait limit reached", $time);
    print_verdict();
  endtask : timed_out

  task automatic put(input logic [31:0] w, input int n);
    for (int j = 0; j < n; j++) e.push_back(w[8*j +: 8]);
  endtask : put

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) timed_out();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Dual modes feed the same firing round to both blocks
  always @(posedge pclk) begin
    if (meas_valid && meas_ready) begin
      meas_valid <= 1'b0;
    end else if (meas_ready === 1'b1 && !meas_valid) begin
      check({meas_block, meas_channel}, exp_idx);
      exp_idx++;
      rs = (dual || !meas_block) ? 0 : 1;
      for (int q = 0; q < 5; q++) begin
        md[q] <= d[rs][meas_channel][q];
        mr[q] <= r[rs][meas_channel][q];
      end
      meas_fired <= fl[rs][meas_channel][0];
      meas_hits <= fl[rs][meas_channel][2:1];
      first_is_strongest <= fl[rs][meas_channel][3];
      last_is_strongest <= fl[rs][meas_channel][4];
      meas_valid <= 1'b1;
    end
  end

  task automatic run_frame(input int i);
    logic [31:0] x, rd, sw, cr;
    logic er, blk;
    logic [4:0] f;
    logic [15:0] dv, fc;
    logic [15:0] az [2];
    logic [7:0] sb;
    int base, s, k, sf, cyc;
    mode = modes[i];
    dual = i >= 5;
    blk = i[0];
    for (int b = 0; b < 2; b++) begin
      for (int c = 0; c < CHANNELS; c++) begin
        x = rnd();
        fl[b][c] = {x[4:1], x[7:5] != 3'h0};
        for (int q = 0; q < 5; q++) begin
          x = rnd();
          d[b][c][q] = x[18:16] == 3'h0 ? {12'h000, x[3:0]} : x[15:0];
          r[b][c][q] = x[31:24];
        end
      end
    end
    x = rnd();
    fc = x[31:16];
    sw = {16'h0000, x[19:16], x[11:8], 3'h0, 1'b0, x[12], 3'(x[2:0] % 3'h5)};
    apb(1'b1, ADDR_CTRL, {16'h0000, mode, 7'h00, blk}, rd, er);
    apb(1'b1, ADDR_SAFETY, sw, rd, er);
    apb(1'b1, ADDR_FAULT, {16'h0000, fc}, rd, er);
    apb(1'b0, ADDR_SAFETY, 32'h00000000, rd, er);
    check(rd & 32'h0000FF1F, sw);
    check({31'h00000000, er}, 32'h00000000);
    apb(1'b0, ADDR_FAULT, 32'h00000000, rd, er);
    check(rd, {16'h0000, fc});
    x = rnd();
    az[0] = x[15:0];
    az[1] = x[31:16];
    for (k = 0; k < 100 && frame_ready !== 1'b1; k++) @(posedge pclk);
    if (frame_ready !== 1'b1) timed_out();
    exp_idx = 8'h00;
    base = i_host_receiver.rx_q.size();
    frame_start <= 1'b1;
    azimuth_first <= az[0];
    azimuth_second <= az[1];
    @(posedge pclk);
    frame_start <= 1'b0;
    for (k = 0; k < 40000 && i_host_receiver.rx_q.size() < base + 1049; k++) @(posedge pclk);
    if (i_host_receiver.rx_q.size() < base + 1049) timed_out();
    e.delete();
    for (int b = 0; b < 2; b++) begin
      put(az[b], 2);
      for (int c = 0; c < CHANNELS; c++) begin
        s = dual ? 0 : b;
        f = fl[s][c];
        k = pick(mode, b[0], f);
        dv = d[s][c][k];
        if (f[2:1] == 2'h0 || dv < MIN_DIST) dv = blk ? NO_POINT_FLAG : 16'h0000;
        put(f[0] ? {8'h00, r[s][c][k], dv} : 32'h00000000, 4);
      end
    end
    cr = CRC_INIT;
    foreach (e[j]) cr = crc8(cr, e[j]);
    put(cr, 4);
    sb = i_host_receiver.rx_q[base + 1033];
    cyc = int'((i_host_receiver.rx_t[base + 1033] - t_rel) / 10);
    check(sb[2:0] === 3'(cyc / ROLL) || sb[2:0] === 3'(cyc / ROLL - 1), 1);
    put(32'(SAFETY_VERSION), 1);
    sf = e.size();
    put(32'({sw[2:0], sw[4:3], sb[2:0]}), 1);
    put(32'({sw[11:8], sw[15:12]}), 1);
    put(32'(fc), 2);
    put(32'h00000000, 4);
    put(32'h00000000, 4);
    cr = CRC_INIT;
    for (int j = sf; j < e.size(); j++) cr = crc8(cr, e[j]);
    put(cr, 4);
    foreach (e[j]) check(i_host_receiver.rx_q[base + j], e[j]);
    check({i_host_receiver.rx_l[base + 1047], i_host_receiver.rx_l[base + 1048]}, 32'h00000001);
    check(firing_order, i < 5 ? 1 : (i - 5) % 2);
  endtask : run_frame

  initial begin
    logic [31:0] rd, r0;
    logic er;
    logic [2:0] nx;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_rel = $time;
    apb(1'b0, ADDR_CTRL, 32'h00000000, rd, er);
    check(rd, {16'h0000, CTRL_MODE_RESET, 8'h00});
    apb(1'b0, 8'h10, 32'h00000000, rd, er);
    check({31'h00000000, er}, 32'h00000001);
    check(rd, 32'h00000000);
    apb(1'b0, ADDR_STATUS, 32'h00000000, r0, er);
    repeat (ROLL - 3) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h00000000, rd, er);
    nx = r0[4:2] + 3'h1;
    check(rd[4:2], nx);
    for (int i = 0; i < 10; i++) run_frame(i);
    // Ten packets sent, idle, last dual packet left the order bit low
    apb(1'b0, ADDR_STATUS, 32'h00000000, rd, er);
    check({rd[31:16], 14'h0000, rd[1:0]}, {16'h000A, 16'h0000});
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
